// *** logic/isf_edge_detect.sv ***
/*
 Change detector: synchronises a bank of level inputs and pulses for one
 cycle on any change. Assumes inputs may be asynchronous to mclk.
*/
`timescale 1ns/1ps
module isf_edge_detect import isf_pkg::*; #(
  parameter int W = ISF_NUM_VALID
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] change_pulse
);
  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;
  logic [W-1:0] last_reg;

  // Two-stage synchroniser, then history stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // Reset to the valid level so release gives no false change
      sync1_reg <= '1;
      sync2_reg <= '1;
      last_reg  <= '1;
    end else begin
      sync1_reg <= level_in;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  // Pulse on either direction of change
  assign change_pulse = sync2_reg ^ last_reg;
endmodule : isf_edge_detect

// *** logic/isf_miss_detect.sv ***
/*
 Fast loss detector: counts sample ticks with no reference edge and flags
 once the count reaches the missing-cycle limit. Assumes ref edges and the
 expected-cycle tick are synchronous single-cycle pulses.
*/
`timescale 1ns/1ps
module isf_miss_detect import isf_pkg::*; (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ref_edge,
  input  wire logic cycle_tick,
  output logic      lost_pulse
);
  logic [1:0] miss_reg;
  logic       seen_reg;

  // Count expected cycles that passed with no edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      miss_reg <= 2'h0;
      seen_reg <= 1'b0;
    end else if (cycle_tick) begin
      seen_reg <= ref_edge;
      if (seen_reg || ref_edge)
        miss_reg <= 2'h0;
      else if (miss_reg != 2'(ISF_MISS_LIMIT))
        miss_reg <= miss_reg + 2'h1;
    end else if (ref_edge) begin
      seen_reg <= 1'b1;
    end
  end

  // One pulse when the limit is first reached
  assign lost_pulse = cycle_tick && !seen_reg && !ref_edge
                      && (miss_reg == 2'(ISF_MISS_LIMIT - 1));
endmodule : isf_miss_detect

// *** logic/isf_pkg.sv ***
/*
 Constants for the input status interrupt flag block: register offsets,
 field positions, reset values, operating modes and timing figures.
 Assumes a byte-wide register port with a 7-bit address.
*/
package isf_pkg;
  // Register offsets
  localparam logic [6:0] ISF_OFS_STATUS_LOW   = 7'h05;
  localparam logic [6:0] ISF_OFS_STATUS_MID   = 7'h06;
  localparam logic [6:0] ISF_OFS_FREQ_TOP     = 7'h07;
  localparam logic [6:0] ISF_OFS_SOURCE_SEL   = 7'h4b;
  // Field positions, low byte
  localparam int ISF_BIT_REF1_SE   = 2;
  localparam int ISF_BIT_REF2_SE   = 3;
  localparam int ISF_BIT_REF1_DIFF = 4;
  localparam int ISF_BIT_REF2_DIFF = 5;
  // Field positions, mid byte
  localparam int ISF_BIT_STANDBY   = 0;
  localparam int ISF_BIT_REF_LOST  = 6;
  localparam int ISF_BIT_MODE      = 7;
  // Loop select bit in the source-select register
  localparam int ISF_BIT_LOOP_SEL  = 4;
  // Reset values and implemented masks
  localparam logic [7:0] ISF_RST_LOW   = 8'hff;
  localparam logic [7:0] ISF_RST_MID   = 8'h3f;
  localparam logic [7:0] ISF_RST_FREQ  = 8'h00;
  localparam logic [7:0] ISF_RST_SRC   = 8'h00;
  localparam logic [7:0] ISF_MASK_LOW  = 8'h3c;
  localparam logic [7:0] ISF_MASK_MID  = 8'hc1;
  // Missing-cycle detector and validity input count
  localparam int         ISF_MISS_LIMIT = 2;
  localparam int         ISF_NUM_VALID  = 5;
  // Operating modes
  typedef enum logic [2:0] {
    ISF_MODE_FREE_RUN = 3'b001,
    ISF_MODE_HOLDOVER = 3'b010,
    ISF_MODE_LOCKED   = 3'b100,
    ISF_MODE_ACQUIRE  = 3'b011
  } isf_mode_e;
endpackage : isf_pkg

// *** logic/isf_status_regs.sv ***
/*
 Input status interrupt flags: two latched write-one-to-clear status bytes
 and a read-only loop frequency top-bits byte on a byte register port.
 Assumes validity levels may be asynchronous; mode, frequency and ref
 edge/tick inputs are synchronous to mclk.
*/
//
// Contract
// R1: Low byte holds status bits 7..0; positions 7,6,1,0 unused.
// R2: Bit 3 flags ref2 single-ended validity change, bit 2 ref1.
// R3: Bit 5 flags ref2 differential validity change, bit 4 ref1.
// R4: Flags stay latched; writing one clears that flag.
// R5: Mid byte bit 7 sets on any operating mode change.
// R6: Mid byte bit 6 sets after 2 missing primary loop ref cycles.
// R7: Reference-lost flag suppressed in free-run or holdover.
// R8: Mid byte bit 0 flags stand-by validity change; bits 5..1 unused.
// R9: Read-only byte returns loop frequency bits 18..16 in bits 2..0.
// R10: Select bit zero reports primary loop, one reports secondary.
// R11: A set in the same cycle as a clear wins.
`timescale 1ns/1ps
module isf_status_regs import isf_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        ref1_se_valid,
  input  wire logic        ref2_se_valid,
  input  wire logic        ref1_diff_valid,
  input  wire logic        ref2_diff_valid,
  input  wire logic        standby_valid,
  input  wire logic [2:0]  op_mode,
  input  wire logic        primary_ref_edge,
  input  wire logic        primary_cycle_tick,
  input  wire logic [18:0] primary_loop_freq,
  input  wire logic [18:0] secondary_loop_freq,
  output logic      [7:0]  irq_status_low_byte,
  output logic      [7:0]  irq_status_mid_byte
);
  logic [7:0]            low_reg;
  logic [7:0]            mid_reg;
  logic [7:0]            src_sel_reg;
  logic [7:0]            rdata_reg;
  logic [2:0]            mode_last_reg;
  logic [ISF_NUM_VALID-1:0] valid_bus;
  logic [ISF_NUM_VALID-1:0] change;
  logic                  lost_raw;
  logic                  ref_lost_event;
  logic                  mode_event;
  logic [7:0]            low_set;
  logic [7:0]            mid_set;
  logic [7:0]            low_clr;
  logic [7:0]            mid_clr;
  logic [7:0]            freq_top;
  logic                  in_fallback;

  assign valid_bus = {standby_valid, ref2_diff_valid, ref1_diff_valid,
                      ref2_se_valid, ref1_se_valid};

  // Validity change detection
  isf_edge_detect #(.W(ISF_NUM_VALID)) u_edges (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .level_in     (valid_bus),
    .change_pulse (change)
  );

  // Fast loss detection on the primary loop reference
  isf_miss_detect u_miss (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ref_edge   (primary_ref_edge),
    .cycle_tick (primary_cycle_tick),
    .lost_pulse (lost_raw)
  );

  // Mode history for change detection
  always_ff @(posedge mclk) begin
    if (!rst_n)
      mode_last_reg <= ISF_MODE_FREE_RUN;
    else
      mode_last_reg <= op_mode;
  end

  assign mode_event  = (op_mode != mode_last_reg); // [R5]
  assign in_fallback = (op_mode == ISF_MODE_FREE_RUN)
                       || (op_mode == ISF_MODE_HOLDOVER); // [R7]
  assign ref_lost_event = lost_raw && !in_fallback; // [R6] [R7]

  // Set vectors for the two status bytes
  always_comb begin
    low_set = 8'h00;
    mid_set = 8'h00;
    low_set[ISF_BIT_REF1_SE]   = change[0]; // [R2]
    low_set[ISF_BIT_REF2_SE]   = change[1]; // [R2]
    low_set[ISF_BIT_REF1_DIFF] = change[2]; // [R3]
    low_set[ISF_BIT_REF2_DIFF] = change[3]; // [R3]
    mid_set[ISF_BIT_STANDBY]   = change[4]; // [R8]
    mid_set[ISF_BIT_REF_LOST]  = ref_lost_event; // [R6]
    mid_set[ISF_BIT_MODE]      = mode_event; // [R5]
  end

  // Write-one-to-clear strobes
  assign low_clr = (reg_wr && reg_addr == ISF_OFS_STATUS_LOW) ? reg_wdata : 8'h00; // [R4]
  assign mid_clr = (reg_wr && reg_addr == ISF_OFS_STATUS_MID) ? reg_wdata : 8'h00; // [R4]

  // Latched flags; unused positions keep their reset value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_reg <= ISF_RST_LOW;
      mid_reg <= ISF_RST_MID;
    end else begin
      low_reg <= (low_reg & ~(low_clr & ISF_MASK_LOW)) | low_set; // [R1] [R4] [R11]
      mid_reg <= (mid_reg & ~(mid_clr & ISF_MASK_MID)) | mid_set; // [R8] [R4] [R11]
    end
  end

  // Source-select configuration register
  always_ff @(posedge mclk) begin
    if (!rst_n)
      src_sel_reg <= ISF_RST_SRC;
    else if (reg_wr && reg_addr == ISF_OFS_SOURCE_SEL)
      src_sel_reg <= reg_wdata;
  end

  // Frequency top bits from the selected loop
  always_comb begin
    freq_top = ISF_RST_FREQ;
    if (src_sel_reg[ISF_BIT_LOOP_SEL])
      freq_top[2:0] = secondary_loop_freq[18:16]; // [R10] [R9]
    else
      freq_top[2:0] = primary_loop_freq[18:16]; // [R10] [R9]
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        ISF_OFS_STATUS_LOW: rdata_reg <= low_reg;
        ISF_OFS_STATUS_MID: rdata_reg <= mid_reg;
        ISF_OFS_FREQ_TOP:   rdata_reg <= freq_top; // [R9]
        ISF_OFS_SOURCE_SEL: rdata_reg <= src_sel_reg;
        default:            rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata           = rdata_reg;
  assign irq_status_low_byte = low_reg;
  assign irq_status_mid_byte = mid_reg;

  // Checks
  property p_r2_ref1_se;
    @(posedge mclk) disable iff (!rst_n) change[0] |=> low_reg[ISF_BIT_REF1_SE];
  endproperty
  a_r2_ref1_se: assert property (p_r2_ref1_se) else $error("ref1 se flag missed"); // [R2]

  property p_r3_ref2_diff;
    @(posedge mclk) disable iff (!rst_n) change[3] |=> low_reg[ISF_BIT_REF2_DIFF];
  endproperty
  a_r3_ref2_diff: assert property (p_r3_ref2_diff) else $error("ref2 diff flag missed"); // [R3]

  sequence s_clear_mode;
    reg_wr && reg_addr == ISF_OFS_STATUS_MID && reg_wdata[ISF_BIT_MODE] && !mode_event;
  endsequence
  property p_r4_clear;
    @(posedge mclk) disable iff (!rst_n) s_clear_mode |=> !mid_reg[ISF_BIT_MODE];
  endproperty
  a_r4_clear: assert property (p_r4_clear) else $error("w1c did not clear"); // [R4]

  property p_r4_hold;
    @(posedge mclk) disable iff (!rst_n)
      low_reg[ISF_BIT_REF2_SE] && !low_clr[ISF_BIT_REF2_SE] |=> low_reg[ISF_BIT_REF2_SE];
  endproperty
  a_r4_hold: assert property (p_r4_hold) else $error("flag dropped without clear"); // [R4]

  property p_r5_mode;
    @(posedge mclk) disable iff (!rst_n) $changed(op_mode) |=> mid_reg[ISF_BIT_MODE];
  endproperty
  a_r5_mode: assert property (p_r5_mode) else $error("mode change flag missed"); // [R5]

  property p_r7_suppress;
    @(posedge mclk) disable iff (!rst_n)
      in_fallback && !mid_reg[ISF_BIT_REF_LOST] |=> !mid_reg[ISF_BIT_REF_LOST];
  endproperty
  a_r7_suppress: assert property (p_r7_suppress) else $error("ref lost in fallback"); // [R7]

  property p_r8_standby;
    @(posedge mclk) disable iff (!rst_n)
      $changed(valid_bus[4]) |-> ##3 mid_reg[ISF_BIT_STANDBY];
  endproperty
  a_r8_standby: assert property (p_r8_standby) else $error("standby flag missed"); // [R8]

  property p_r10_read;
    @(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == ISF_OFS_FREQ_TOP && !src_sel_reg[ISF_BIT_LOOP_SEL]
      |=> reg_rdata == {5'h00, $past(primary_loop_freq[18:16])};
  endproperty
  a_r10_read: assert property (p_r10_read) else $error("wrong loop reported"); // [R10]

  property p_r11_set_wins;
    @(posedge mclk) disable iff (!rst_n)
      change[2] && low_clr[ISF_BIT_REF1_DIFF] |=> low_reg[ISF_BIT_REF1_DIFF];
  endproperty
  a_r11_set_wins: assert property (p_r11_set_wins) else $error("event lost on clear"); // [R11]

  // Flags that must survive, or must be wiped, at the coming edge
  logic [7:0] low_keep;
  logic [7:0] mid_keep;
  logic [7:0] low_wipe;
  logic [7:0] mid_wipe;
  assign low_keep = low_reg & ~low_clr;
  assign mid_keep = mid_reg & ~mid_clr;
  assign low_wipe = low_clr & ISF_MASK_LOW & ~low_set;
  assign mid_wipe = mid_clr & ISF_MASK_MID & ~mid_set;

  // Register port requests shared by several checks
  sequence s_low_write;
    reg_wr && reg_addr == ISF_OFS_STATUS_LOW;
  endsequence
  sequence s_mid_write;
    reg_wr && reg_addr == ISF_OFS_STATUS_MID;
  endsequence
  sequence s_freq_read;
    reg_rd && reg_addr == ISF_OFS_FREQ_TOP;
  endsequence

  // Unused positions never leave their reset value
  property p_r1_low_unused;
    @(posedge mclk) disable iff (!rst_n)
      (low_reg & ~ISF_MASK_LOW) == (ISF_RST_LOW & ~ISF_MASK_LOW);
  endproperty
  a_r1_low_unused: assert property (p_r1_low_unused) else $error("low spare moved"); // [R1]

  property p_r8_mid_unused;
    @(posedge mclk) disable iff (!rst_n)
      (mid_reg & ~ISF_MASK_MID) == (ISF_RST_MID & ~ISF_MASK_MID);
  endproperty
  a_r8_mid_unused: assert property (p_r8_mid_unused) else $error("mid spare moved"); // [R8]

  // Remaining change inputs set their flags
  property p_r2_ref2_se;
    @(posedge mclk) disable iff (!rst_n) change[1] |=> low_reg[ISF_BIT_REF2_SE];
  endproperty
  a_r2_ref2_se: assert property (p_r2_ref2_se) else $error("ref2 se flag missed"); // [R2]

  property p_r3_ref1_diff;
    @(posedge mclk) disable iff (!rst_n) change[2] |=> low_reg[ISF_BIT_REF1_DIFF];
  endproperty
  a_r3_ref1_diff: assert property (p_r3_ref1_diff) else $error("ref1 diff missed"); // [R3]

  // No flag rises without its event
  property p_r2_quiet;
    @(posedge mclk) disable iff (!rst_n)
      !low_reg[ISF_BIT_REF1_SE] && !change[0] |=> !low_reg[ISF_BIT_REF1_SE];
  endproperty
  a_r2_quiet: assert property (p_r2_quiet) else $error("spurious ref1 se flag"); // [R2]

  property p_r5_quiet;
    @(posedge mclk) disable iff (!rst_n)
      !mid_reg[ISF_BIT_MODE] && !mode_event |=> !mid_reg[ISF_BIT_MODE];
  endproperty
  a_r5_quiet: assert property (p_r5_quiet) else $error("spurious mode flag"); // [R5]

  // Flags survive every edge unless written with a one
  property p_r4_keep_low;
    @(posedge mclk) disable iff (!rst_n)
      1'b1 |=> (low_reg & $past(low_keep)) == $past(low_keep);
  endproperty
  a_r4_keep_low: assert property (p_r4_keep_low) else $error("low flag dropped"); // [R4]

  property p_r4_keep_mid;
    @(posedge mclk) disable iff (!rst_n)
      1'b1 |=> (mid_reg & $past(mid_keep)) == $past(mid_keep);
  endproperty
  a_r4_keep_mid: assert property (p_r4_keep_mid) else $error("mid flag dropped"); // [R4]

  // A one written to a flag clears it unless its event fires
  property p_r4_clear_low;
    @(posedge mclk) disable iff (!rst_n)
      s_low_write |=> (low_reg & $past(low_wipe)) == 8'h00;
  endproperty
  a_r4_clear_low: assert property (p_r4_clear_low) else $error("low not cleared"); // [R4]

  property p_r4_clear_mid;
    @(posedge mclk) disable iff (!rst_n)
      s_mid_write |=> (mid_reg & $past(mid_wipe)) == 8'h00;
  endproperty
  a_r4_clear_mid: assert property (p_r4_clear_mid) else $error("mid not cleared"); // [R4]

  // Mode change beats a clear in the same cycle
  property p_r11_mode_wins;
    @(posedge mclk) disable iff (!rst_n)
      mode_event && mid_clr[ISF_BIT_MODE] |=> mid_reg[ISF_BIT_MODE];
  endproperty
  a_r11_mode_wins: assert property (p_r11_mode_wins) else $error("mode event lost"); // [R11]

  // Loss outside fallback modes reaches the flag
  property p_r6_lost;
    @(posedge mclk) disable iff (!rst_n)
      lost_raw && !in_fallback |=> mid_reg[ISF_BIT_REF_LOST];
  endproperty
  a_r6_lost: assert property (p_r6_lost) else $error("ref lost flag missed"); // [R6]

  // Frequency byte: zero padding and secondary loop
  property p_r9_pad;
    @(posedge mclk) disable iff (!rst_n)
      s_freq_read |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_r9_pad: assert property (p_r9_pad) else $error("freq padding wrong"); // [R9]

  property p_r10_secondary;
    @(posedge mclk) disable iff (!rst_n) s_freq_read ##0 src_sel_reg[ISF_BIT_LOOP_SEL]
      |=> reg_rdata == {5'h00, $past(secondary_loop_freq[18:16])};
  endproperty
  a_r10_secondary: assert property (p_r10_secondary) else $error("wrong loop"); // [R10]

  // Status reads return the flags as they stood
  property p_r1_read_low;
    @(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == ISF_OFS_STATUS_LOW |=> reg_rdata == $past(low_reg);
  endproperty
  a_r1_read_low: assert property (p_r1_read_low) else $error("low read wrong"); // [R1]

  property p_r8_read_mid;
    @(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == ISF_OFS_STATUS_MID |=> reg_rdata == $past(mid_reg);
  endproperty
  a_r8_read_mid: assert property (p_r8_read_mid) else $error("mid read wrong"); // [R8]
endmodule : isf_status_regs

// *** tb/testbench.sv ***
/*
 Self-checking bench for the input status flag block: byte register
 reads and writes, validity toggles, mode changes and missed ref cycles.
 Assumes the design files and isf_pkg are compiled first.
*/
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp); end end
module testbench import isf_pkg::*;;
  logic        mclk, rst_n, reg_wr, reg_rd, edge_p, tick;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, rdv;
  logic [4:0]  vld;
  logic [2:0]  op_mode;
  logic [18:0] pf, sf;
  wire  [7:0]  reg_rdata, low, mid;
  int          err_total, comparisons, cyc;

  // Device under test
  isf_status_regs i_isf_status_regs (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref1_se_valid(vld[0]), .ref2_se_valid(vld[1]), .ref1_diff_valid(vld[2]),
    .ref2_diff_valid(vld[3]), .standby_valid(vld[4]), .op_mode(op_mode),
    .primary_ref_edge(edge_p), .primary_cycle_tick(tick), .primary_loop_freq(pf),
    .secondary_loop_freq(sf), .irq_status_low_byte(low), .irq_status_mid_byte(mid));

  // Clock and hang guard
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic cyc_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc_n

  // One write strobe, then one spare cycle for the flag update
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    cyc_n(1);
    reg_wr = 1'b0;
    cyc_n(1);
  endtask : wr

  // One read strobe, data sampled once settled
  task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd   = 1'b1;
    cyc_n(1);
    reg_rd = 1'b0;
    cyc_n(1);
    rdv = reg_rdata;
    `CHK(rdv, e)
  endtask : chk_rd

  // Ref edge, expected-cycle tick or both, for one cycle
  task automatic pulse(input logic e, input logic t);
    edge_p = e;
    tick   = t;
    cyc_n(1);
    edge_p = 1'b0;
    tick   = 1'b0;
    cyc_n(2);
  endtask : pulse

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    {reg_wr, reg_rd, edge_p, tick, reg_addr, reg_wdata} = '0;
    vld = 5'h1f;
    op_mode = ISF_MODE_FREE_RUN;
    pf = 19'h5_0000;
    sf = 19'h2_ffff;
    rst_n = 1'b0;
    cyc_n(3);
    `CHK(low, 8'hff)
    `CHK(mid, 8'h3f)
    `CHK(reg_rdata, 8'h00)
    rst_n = 1'b1;
    cyc_n(5);
    wr(ISF_OFS_STATUS_LOW, 8'hff);
    wr(ISF_OFS_STATUS_MID, 8'hff);
    chk_rd(ISF_OFS_STATUS_LOW, 8'hc3);
    chk_rd(ISF_OFS_STATUS_MID, 8'h3e);
    // Each validity input, falling then rising
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        vld[i] = ~vld[i];
        cyc_n(5);
        wr(ISF_OFS_STATUS_LOW, 8'h00);
        `CHK(low, 8'hc3 | (8'h01 << (i + 2)))
        wr(ISF_OFS_STATUS_LOW, 8'h01 << (i + 2));
        `CHK(low, 8'hc3)
      end
      vld[4] = ~vld[4];
      cyc_n(5);
      chk_rd(ISF_OFS_STATUS_MID, 8'h3f);
      wr(ISF_OFS_STATUS_MID, 8'h01);
      `CHK(mid, 8'h3e)
    end
    // Event and clear in one cycle: the event wins
    vld[2] = ~vld[2];
    cyc_n(2);
    wr(ISF_OFS_STATUS_LOW, 8'h10);
    `CHK(low, 8'hd3)
    wr(ISF_OFS_STATUS_LOW, 8'h10);
    `CHK(low, 8'hc3)
    op_mode = ISF_MODE_ACQUIRE;
    wr(ISF_OFS_STATUS_MID, 8'h80);
    `CHK(mid, 8'hbe)
    wr(ISF_OFS_STATUS_MID, 8'h80);
    `CHK(mid, 8'h3e)
    // Mode change, then missed ref cycles while locked
    op_mode = ISF_MODE_LOCKED;
    cyc_n(2);
    `CHK(mid, 8'hbe)
    wr(ISF_OFS_STATUS_MID, 8'h80);
    `CHK(mid, 8'h3e)
    pulse(1'b0, 1'b1);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    `CHK(mid, 8'h3e)
    pulse(1'b0, 1'b1);
    `CHK(mid, 8'h3e)
    pulse(1'b0, 1'b1);
    `CHK(mid, 8'h7e)
    wr(ISF_OFS_STATUS_MID, 8'h40);
    // No loss flag in holdover or free-run
    for (int m = 0; m < 2; m++) begin
      op_mode = m ? ISF_MODE_FREE_RUN : ISF_MODE_HOLDOVER;
      cyc_n(2);
      wr(ISF_OFS_STATUS_MID, 8'h80);
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      pulse(1'b0, 1'b1);
      pulse(1'b0, 1'b1);
      `CHK(mid, 8'h3e)
    end
    // Frequency top bits from either loop
    chk_rd(ISF_OFS_FREQ_TOP, 8'h05);
    wr(ISF_OFS_FREQ_TOP, 8'hff);
    wr(ISF_OFS_SOURCE_SEL, 8'h10);
    chk_rd(ISF_OFS_FREQ_TOP, 8'h02);
    wr(ISF_OFS_SOURCE_SEL, 8'h00);
    chk_rd(ISF_OFS_FREQ_TOP, 8'h05);
    chk_rd(7'h10, 8'h00);
    give_verdict();
  end
endmodule : testbench
